// *** rcw_pkg.sv ***
// Package: register map, field positions, reset values and counts for the watchdog
package rcw_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] SERVICE_PORT_ADDR = 16'hffff;
    localparam logic [15:0] CONFIG_ONE_ADDR   = 16'hff00;
    localparam logic [15:0] CAUSE_REG_ADDR    = 16'hff01;
    localparam logic [15:0] STATUS_REG_ADDR   = 16'hff02;
    // Field positions in system_config_one
    localparam int CFG_DISABLE_POS = 0;
    localparam int CFG_RATE_POS    = 1;
    localparam int CFG_STOPEN_POS  = 2;
    localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
    // Field positions of the watchdog and illegal-op flags in reset_cause_register
    localparam int CAUSE_WDOG_POS  = 1;
    localparam int CAUSE_ILLOP_POS = 2;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int PRESCALE_BITS   = 12;
    localparam int COUNTER_BITS    = 6;
    localparam int SERVICE_LOW_BIT = 4;
    localparam int LONG_TAP        = 11;
    localparam int SHORT_TAP       = 6;
    localparam int PIN_LOW_CYCLES  = 32;
    localparam int POR_CLEAR_CYCLES = 4096;
endpackage : rcw_pkg

// *** rcw_watchdog.sv ***
// Runaway code watchdog: prescaler, timeout counter, service port and reset request
`timescale 1ns/10ps
module rcw_watchdog #(
    parameter int PorClearCycles = rcw_pkg::POR_CLEAR_CYCLES,
    parameter logic [7:0] ResetVectorLow = 8'h00  // Arbitrary default
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] busAddr,
    input  wire logic [7:0]  busWrData,
    input  wire logic        busWrStb,
    input  wire logic        busRdStb,
    output logic      [7:0]  busRdData,
    input  wire logic        internalReset,
    input  wire logic        powerOnReset,
    input  wire logic        resetVectorFetch,
    input  wire logic        stopExec,
    input  wire logic        stopMode,
    input  wire logic        breakState,
    input  wire logic        monitorMode,
    input  wire logic        monitorBlankEntry,
    input  wire logic        irqPinTestVoltage,
    input  wire logic        rstPinTestVoltage,
    output logic             resetRequest,
    output logic             illegalOpReset,
    output logic             resetPinLow_b,
    output logic             cpuIrq
);
    // ------------------------------------------------------------
    // Pin synchronisers, three stages, change taken when two and three agree
    // ------------------------------------------------------------
    logic [2:0] irqTstSync_q;
    logic [2:0] rstTstSync_q;
    logic       irqTst_q;
    logic       rstTst_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqTstSync_q <= 3'h0;
            rstTstSync_q <= 3'h0;
        end else begin
            irqTstSync_q <= {irqTstSync_q[1:0], irqPinTestVoltage};
            rstTstSync_q <= {rstTstSync_q[1:0], rstPinTestVoltage};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqTst_q <= 1'b0;
            rstTst_q <= 1'b0;
        end else begin
            if (irqTstSync_q[1] == irqTstSync_q[2]) begin
                irqTst_q <= irqTstSync_q[2];
            end
            if (rstTstSync_q[1] == rstTstSync_q[2]) begin
                rstTst_q <= rstTstSync_q[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration and cause registers
    // ------------------------------------------------------------
    logic [7:0] configOne_q;
    logic       wdogCause_q;
    logic       illopCause_q;
    logic       blankLatch_q;
    logic       wasMonitor_q;
    logic       monTstEntry_q;

    wire logic wrService = busWrStb && (busAddr == rcw_pkg::SERVICE_PORT_ADDR);
    wire logic wrConfig  = busWrStb && (busAddr == rcw_pkg::CONFIG_ONE_ADDR);
    wire logic wrCause   = busWrStb && (busAddr == rcw_pkg::CAUSE_REG_ADDR);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            configOne_q <= rcw_pkg::CONFIG_ONE_RESET;
        end else if (internalReset) begin
            configOne_q <= rcw_pkg::CONFIG_ONE_RESET;
        end else if (wrConfig) begin
            configOne_q <= busWrData;
        end
    end

    wire logic rateShort   = configOne_q[rcw_pkg::CFG_RATE_POS];
    wire logic disableBit  = configOne_q[rcw_pkg::CFG_DISABLE_POS];
    wire logic stopBlocked = configOne_q[rcw_pkg::CFG_STOPEN_POS];

    // Blank-vector monitor entry holds the watchdog off until power-on only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            blankLatch_q <= 1'b0;
        end else if (powerOnReset) begin
            blankLatch_q <= 1'b0;
        end else if (monitorMode && monitorBlankEntry && !irqTst_q) begin
            blankLatch_q <= 1'b1;
        end
    end

    // Remember how monitor mode was entered: test voltage on irq pin at entry
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wasMonitor_q  <= 1'b0;
            monTstEntry_q <= 1'b0;
        end else begin
            wasMonitor_q <= monitorMode;
            if (monitorMode && !wasMonitor_q) begin
                monTstEntry_q <= irqTst_q;
            end else if (!monitorMode) begin
                monTstEntry_q <= 1'b0;
            end
        end
    end

    wire logic monTstOff = monitorMode && monTstEntry_q && (irqTst_q || rstTst_q);
    wire logic breakOff  = breakState && rstTst_q;
    wire logic wdogOff   = disableBit || monTstOff || blankLatch_q || breakOff;

    // ------------------------------------------------------------
    // Power-on prescaler clear
    // ------------------------------------------------------------
    localparam int PorW = $clog2(PorClearCycles + 1);
    logic [PorW-1:0] porCount_q;
    logic            porClear;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            porCount_q <= '0;
        end else if (powerOnReset) begin
            porCount_q <= '0;
        end else if (porCount_q != PorW'(PorClearCycles)) begin
            porCount_q <= porCount_q + PorW'(1);
        end
    end

    // One-cycle clear when the power-up count completes
    assign porClear = (porCount_q == PorW'(PorClearCycles - 1));

    // ------------------------------------------------------------
    // Prescaler and timeout counter
    // ------------------------------------------------------------
    logic [rcw_pkg::PRESCALE_BITS-1:0] prescale_q;
    logic [rcw_pkg::COUNTER_BITS-1:0]  counter_q;
    logic                              tapPrev_q;
    logic                              request_q;

    // Service clears stages 12..5 only, so the low four bits keep running;
    // this is why a timeout is short by up to 2^4 cycles, plus one period of the selected stage if that stage was high at service.
    localparam logic [rcw_pkg::PRESCALE_BITS-1:0] LowMask =
        rcw_pkg::PRESCALE_BITS'((1 << rcw_pkg::SERVICE_LOW_BIT) - 1);

    wire logic fullClear = internalReset || porClear || resetVectorFetch || stopExec;
    wire logic running   = !stopMode && !wdogOff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prescale_q <= '0;
        end else if (fullClear) begin
            prescale_q <= '0;
        end else if (wrService) begin
            prescale_q <= (prescale_q & LowMask) + rcw_pkg::PRESCALE_BITS'(running);
        end else if (running) begin
            prescale_q <= prescale_q + rcw_pkg::PRESCALE_BITS'(1);
        end
    end

    // Counter advances on the falling edge of the selected prescaler stage
    wire logic tapBit = rateShort ? prescale_q[rcw_pkg::SHORT_TAP]
                                  : prescale_q[rcw_pkg::LONG_TAP];
    wire logic tapFall = tapPrev_q && !tapBit;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tapPrev_q <= 1'b0;
        end else begin
            tapPrev_q <= tapBit;
        end
    end

    wire logic overflow = running && tapFall && (counter_q == '1) && !wrService;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            counter_q <= '0;
        end else if (internalReset || wrService) begin
            counter_q <= '0;
        end else if (running && tapFall) begin
            counter_q <= counter_q + rcw_pkg::COUNTER_BITS'(1);
        end
    end

    // ------------------------------------------------------------
    // Reset request, pin pulse and cause flags
    // ------------------------------------------------------------
    logic [5:0] pinCount_q;
    logic       illop_q;
    logic       pinLowB_q;
    logic       irqOut_q;

    // Request registered on the overflow edge; the system model samples it on sys_clk and answers after answerDelay
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            request_q <= 1'b0;
        end else if (overflow) begin
            request_q <= 1'b1;
        end else if (internalReset) begin
            request_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            illop_q <= 1'b0;
        end else begin
            illop_q <= stopExec && stopBlocked;
        end
    end

    // Pin level kept active low in its own flop so the port needs no inverter
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinCount_q <= '0;
            pinLowB_q  <= 1'b1;
        end else if (overflow) begin
            pinCount_q <= 6'(rcw_pkg::PIN_LOW_CYCLES - 1);
            pinLowB_q  <= 1'b0;
        end else if (pinCount_q != '0) begin
            pinCount_q <= pinCount_q - 6'(1);
        end else begin
            pinLowB_q <= 1'b1;
        end
    end

    // The watchdog owns no interrupt; the flop only keeps the port registered
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqOut_q <= 1'b0;
        end else begin
            irqOut_q <= 1'b0;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdogCause_q  <= 1'b0;
            illopCause_q <= 1'b0;
        end else begin
            if (overflow) begin
                wdogCause_q <= 1'b1;
            end else if (wrCause || powerOnReset) begin
                wdogCause_q <= 1'b0;
            end
            if (stopExec && stopBlocked) begin
                illopCause_q <= 1'b1;
            end else if (wrCause || powerOnReset) begin
                illopCause_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] rdData_q;
    logic [7:0] rdMux;

    always_comb begin
        rdMux = 8'h00;
        case (busAddr)
            rcw_pkg::SERVICE_PORT_ADDR: rdMux = ResetVectorLow;
            rcw_pkg::CONFIG_ONE_ADDR:   rdMux = configOne_q;
            rcw_pkg::CAUSE_REG_ADDR: begin
                rdMux[rcw_pkg::CAUSE_WDOG_POS]  = wdogCause_q;
                rdMux[rcw_pkg::CAUSE_ILLOP_POS] = illopCause_q;
            end
            rcw_pkg::STATUS_REG_ADDR:   rdMux = {1'b0, wdogOff, counter_q};
            default:                    rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= 8'h00;
        end else if (busRdStb) begin
            rdData_q <= rdMux;
        end else begin
            rdData_q <= 8'h00;
        end
    end

    assign busRdData      = rdData_q;
    assign resetRequest   = request_q;
    assign illegalOpReset = illop_q;
    assign resetPinLow_b  = pinLowB_q;
    assign cpuIrq         = irqOut_q;

endmodule : rcw_watchdog

// *** rcw_sys_model.sv ***
// Model of the system reset logic that answers the watchdog reset request
`timescale 1ns/10ps
module rcw_sys_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       resetRequest,
    input  wire logic [7:0] answerDelay,
    output logic            internalReset
);
    // ------------------------------------------------------------
    // Delayed answer
    // ------------------------------------------------------------
    logic [7:0] waitCnt_q;
    // Answer after a bench-chosen delay; the request must hold meanwhile
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            waitCnt_q     <= 8'h00;
            internalReset <= 1'b0;
        end else if (resetRequest && waitCnt_q == answerDelay) begin
            waitCnt_q     <= 8'h00;
            internalReset <= 1'b1;
        end else begin
            waitCnt_q     <= resetRequest ? waitCnt_q + 8'h01 : 8'h00;
            internalReset <= 1'b0;
        end
    end
endmodule : rcw_sys_model

// *** rcw_watchdog_monitor.sv ***
// Checker on the watchdog top-level ports
`timescale 1ns/10ps
module rcw_watchdog_monitor #(
    parameter logic [7:0] ResetVectorLow = 8'h00
) (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [15:0] busAddr,
    input wire logic        busWrStb,
    input wire logic        busRdStb,
    input wire logic [7:0]  busRdData,
    input wire logic        internalReset,
    input wire logic        stopExec,
    input wire logic        stopMode,
    input wire logic        resetRequest,
    input wire logic        illegalOpReset,
    input wire logic        resetPinLow_b,
    input wire logic        cpuIrq
);
    // ------------------------------------------------------------
    // Helper counters and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [5:0]  lowCnt_q;
    logic [15:0] sinceSvc_q;
    logic        svcWr;
    assign svcWr = busWrStb && busAddr == rcw_pkg::SERVICE_PORT_ADDR;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) lowCnt_q <= 6'h00;
        else if (resetPinLow_b) lowCnt_q <= 6'h00;
        else if (lowCnt_q != 6'h3f) lowCnt_q <= lowCnt_q + 6'h01;
    end
    // Saturates so a long idle stretch cannot wrap into a false short count
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) sinceSvc_q <= 16'h0000;
        else if (svcWr || internalReset) sinceSvc_q <= 16'h0000;
        else if (sinceSvc_q != 16'hffff) sinceSvc_q <= sinceSvc_q + 16'h0001;
    end
    property p_no_irq; cpuIrq == 1'b0; endproperty
    a_no_irq: assert property (p_no_irq) else $error("cpu irq raised");
    property p_req_hold; resetRequest && !internalReset |=> resetRequest; endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_req_clr; internalReset |=> !resetRequest; endproperty
    a_req_clr: assert property (p_req_clr) else $error("request not cleared");
    property p_pin_req; $rose(resetRequest) |-> !resetPinLow_b && $past(resetPinLow_b); endproperty
    a_pin_req: assert property (p_pin_req) else $error("pin not pulled with request");
    property p_pin_len; $rose(resetPinLow_b) |-> lowCnt_q == 6'h20; endproperty
    a_pin_len: assert property (p_pin_len) else $error("pin low length wrong");
    property p_min_tmo; $rose(resetRequest) |-> sinceSvc_q >= 16'h1fe0; endproperty
    a_min_tmo: assert property (p_min_tmo) else $error("timeout too early");
    property p_svc; svcWr && !resetRequest |-> ##2 !resetRequest [*8]; endproperty
    a_svc: assert property (p_svc) else $error("request right after service");
    property p_rd_vec; busRdStb && busAddr == rcw_pkg::SERVICE_PORT_ADDR |=>
        busRdData == ResetVectorLow; endproperty
    a_rd_vec: assert property (p_rd_vec) else $error("service port read wrong");
    property p_rd_idle; !busRdStb |=> busRdData == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_stop; stopMode && $past(stopMode) |-> !$rose(resetRequest); endproperty
    a_stop: assert property (p_stop) else $error("request while stopped");
    property p_ill; illegalOpReset |-> $past(stopExec) ##1 !illegalOpReset; endproperty
    a_ill: assert property (p_ill) else $error("illegal op pulse wrong");
    c_req: cover property ($rose(resetRequest));
    c_ill: cover property (illegalOpReset);
    c_vec: cover property (busRdStb && busAddr == rcw_pkg::SERVICE_PORT_ADDR);
endmodule : rcw_watchdog_monitor

bind rcw_watchdog rcw_watchdog_monitor #(.ResetVectorLow(ResetVectorLow)) u_mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .busAddr(busAddr), .busWrStb(busWrStb),
    .busRdStb(busRdStb), .busRdData(busRdData), .internalReset(internalReset),
    .stopExec(stopExec), .stopMode(stopMode), .resetRequest(resetRequest),
    .illegalOpReset(illegalOpReset), .resetPinLow_b(resetPinLow_b), .cpuIrq(cpuIrq));

// *** tb_top.sv ***
// Self-checking testbench for the runaway code watchdog
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------
    // Stimulus, partner and checks
    // ------------------------------------------------------------
    localparam logic [7:0] VecLow = 8'h5a;  // Arbitrary vector byte
    logic        sys_clk = 1'b0, rst_b = 1'b0, busWrStb = 1'b0, busRdStb = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0]  busWrData = 8'h00, busRdData, answerDelay = 8'h28;
    logic        powerOnReset = 1'b0, resetVectorFetch = 1'b0, stopExec = 1'b0;
    logic        stopMode = 1'b0, breakState = 1'b0, monitorMode = 1'b0;
    logic        monitorBlankEntry = 1'b0, irqPinTestVoltage = 1'b0, rstPinTestVoltage = 1'b0;
    logic        internalReset, resetRequest, illegalOpReset, resetPinLow_b, cpuIrq;
    logic [31:0] lfsr = 32'hffec_a6fa;
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    always #20 sys_clk = ~sys_clk;
    rcw_watchdog #(.PorClearCycles(16), .ResetVectorLow(VecLow)) i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .busAddr(busAddr), .busWrData(busWrData),
        .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData),
        .internalReset(internalReset), .powerOnReset(powerOnReset),
        .resetVectorFetch(resetVectorFetch), .stopExec(stopExec), .stopMode(stopMode),
        .breakState(breakState), .monitorMode(monitorMode),
        .monitorBlankEntry(monitorBlankEntry), .irqPinTestVoltage(irqPinTestVoltage),
        .rstPinTestVoltage(rstPinTestVoltage), .resetRequest(resetRequest),
        .illegalOpReset(illegalOpReset), .resetPinLow_b(resetPinLow_b), .cpuIrq(cpuIrq));
    rcw_sys_model i_sys (.sys_clk(sys_clk), .rst_b(rst_b), .resetRequest(resetRequest),
        .answerDelay(answerDelay), .internalReset(internalReset));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Short timeout plus slack for the registered service and request
    function automatic logic [15:0] in_window(input int d);
        int t;
        t = 2 ** (rcw_pkg::PRESCALE_BITS + 1) - 2 ** rcw_pkg::SERVICE_LOW_BIT;
        in_window = (d >= t - 8 && d <= t + 32) ? 16'h0001 : 16'h0000;
    endfunction : in_window
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busAddr   <= a;
        busWrData <= d;
        busWrStb  <= 1'b1;
        @(posedge sys_clk);
        busWrStb  <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        busAddr  <= a;
        busRdStb <= 1'b1;
        @(posedge sys_clk);
        busRdStb <= 1'b0;
        #1 cmp({8'h00, busRdData}, {8'h00, exp});
    endtask : rd
    // Random vector fetches clear the prescaler, which can lengthen or shorten the period; no request may appear
    task automatic quiet(input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge sys_clk);
            lfsr = lfsr_next(lfsr);
            resetVectorFetch <= (lfsr[7:0] == 8'h00);
            if (resetRequest !== 1'b0) bad++;
        end
        @(posedge sys_clk);
        resetVectorFetch <= 1'b0;
        cmp(bad[15:0], 16'h0000);
    endtask : quiet
    task automatic measure();
        int t0;
        wr(rcw_pkg::CONFIG_ONE_ADDR, 8'h02);
        wr(rcw_pkg::CAUSE_REG_ADDR, 8'h00);
        answerDelay <= 8'h22 + {3'h0, lfsr[4:0]};
        wr(rcw_pkg::SERVICE_PORT_ADDR, lfsr[15:8]);
        t0 = cyc;
        rd(rcw_pkg::SERVICE_PORT_ADDR, VecLow);
        while (resetRequest !== 1'b1 && cyc - t0 < 9000) @(posedge sys_clk);
        cmp(in_window(cyc - t0), 16'h0001);
        while (resetRequest !== 1'b0 && cyc - t0 < 9200) @(posedge sys_clk);
        rd(rcw_pkg::CAUSE_REG_ADDR, 8'h02);
        rd(rcw_pkg::CONFIG_ONE_ADDR, rcw_pkg::CONFIG_ONE_RESET);
    endtask : measure
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fail_count++;
            $display("[FAIL] %0t run timed out", $time);
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        wr(rcw_pkg::SERVICE_PORT_ADDR, 8'h00);
        rd(rcw_pkg::CONFIG_ONE_ADDR, rcw_pkg::CONFIG_ONE_RESET);
        rd(rcw_pkg::SERVICE_PORT_ADDR, VecLow);
        rd(16'hff10, 8'h00);
        wr(rcw_pkg::CONFIG_ONE_ADDR, 8'h02);
        repeat (3) begin
            lfsr = lfsr_next(lfsr);
            wr(rcw_pkg::SERVICE_PORT_ADDR, lfsr[7:0]);
            quiet(2000 + int'(lfsr[23:12]));
        end
        measure();
        wr(rcw_pkg::CONFIG_ONE_ADDR, 8'h03);
        wr(rcw_pkg::SERVICE_PORT_ADDR, 8'hff);
        quiet(9000);
        wr(rcw_pkg::CONFIG_ONE_ADDR, 8'h02);
        wr(rcw_pkg::SERVICE_PORT_ADDR, 8'h3c);
        stopExec <= 1'b1;
        @(posedge sys_clk);
        stopExec <= 1'b0;
        stopMode <= 1'b1;
        quiet(9000);
        stopMode <= 1'b0;
        wr(rcw_pkg::CONFIG_ONE_ADDR, 8'h06);
        wr(rcw_pkg::CAUSE_REG_ADDR, 8'h00);
        stopExec <= 1'b1;
        @(posedge sys_clk);
        stopExec <= 1'b0;
        #1 cmp({15'h0000, illegalOpReset}, 16'h0001);
        rd(rcw_pkg::CAUSE_REG_ADDR, 8'h04);
        breakState <= 1'b1;
        rstPinTestVoltage <= 1'b1;
        repeat (6) @(posedge sys_clk);
        wr(rcw_pkg::SERVICE_PORT_ADDR, 8'h11);
        quiet(9000);
        breakState <= 1'b0;
        rstPinTestVoltage <= 1'b0;
        irqPinTestVoltage <= 1'b1;
        wr(rcw_pkg::SERVICE_PORT_ADDR, 8'h22);
        repeat (6) @(posedge sys_clk);
        monitorMode <= 1'b1;
        quiet(9000);
        monitorMode <= 1'b0;
        irqPinTestVoltage <= 1'b0;
        repeat (6) @(posedge sys_clk);
        wr(rcw_pkg::SERVICE_PORT_ADDR, 8'h33);
        monitorMode <= 1'b1;
        monitorBlankEntry <= 1'b1;
        repeat (2) @(posedge sys_clk);
        monitorMode <= 1'b0;
        monitorBlankEntry <= 1'b0;
        quiet(9000);
        powerOnReset <= 1'b1;
        @(posedge sys_clk);
        powerOnReset <= 1'b0;
        repeat (20) @(posedge sys_clk);
        measure();
        final_report();
    end
endmodule : tb_top
